// ### rtl/eeprom_port_params.svh
// Register offsets, field positions, reset values and timing counts of the EEPROM port
`ifndef EEPROM_PORT_PARAMS_SVH
`define EEPROM_PORT_PARAMS_SVH
`define PORT_CONTROL_OFFSET   8'h90
`define PORT_STATUS_OFFSET    8'h94
`define BIT_POWER             0
`define BIT_DATA              1
`define BIT_CLOCK             2
`define PORT_CONTROL_RESET    3'h7
`define EEPROM_BYTES          128
`define PAGE_BYTES            16
`define PROG_TIME_US          2
`define CLK_MHZ               40
`define PROG_CYCLES           (`PROG_TIME_US * `CLK_MHZ)
`define DEV_ADDR_CODE         4'ha
`endif

// ### rtl/eeprom_port_pkg.sv
// State type of the serial memory behind the EEPROM port
package eeprom_port_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK,
        ST_PROG
    } mem_state_t;
endpackage : eeprom_port_pkg

// ### rtl/serial_eeprom_core.sv
// Two-wire serial EEPROM: line decoder, acknowledge, page buffer and array
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
module serial_eeprom_core #(
    parameter int DEPTH      = `EEPROM_BYTES,
    parameter int PAGE       = `PAGE_BYTES,
    parameter int PROG_COUNT = `PROG_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic powered_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_low_o,
    output logic      busy_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE);

    typedef struct packed {
        logic                   scl_q;
        logic                   sda_q;
        eeprom_port_pkg::mem_state_t st;
        logic [3:0]             bitn;
        logic [7:0]             shift;
        logic [1:0]             phase;
        logic                   rd_mode;
        logic [AW-1:0]          addr;
        logic [PW:0]            nbuf;
        logic [PW-1:0]          head;
        logic                   sda_low;
        logic [15:0]            cnt;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic [7:0]  mem [DEPTH];
    logic [7:0]  page_buf [PAGE];
    logic        wr_buf;
    logic        commit;
    logic [AW-1:0] commit_addr;
    logic [7:0]    commit_data;

    // Array and page buffer storage
    always_ff @(posedge clk_i) begin
        if (wr_buf) begin
            page_buf[s_reg.head] <= s_reg.shift;
        end
        if (commit) begin
            mem[commit_addr] <= commit_data;
        end
    end

    // Programming drains one buffered byte per cycle, oldest first
    always_comb begin
        logic [PW-1:0] idx;
        idx         = PW'(s_reg.head - PW'(s_reg.nbuf));
        commit      = (s_reg.st == eeprom_port_pkg::ST_PROG) && (s_reg.nbuf != '0);
        commit_data = page_buf[idx];
        commit_addr = AW'(s_reg.addr - AW'(s_reg.nbuf));
    end

    // Bus condition decode and byte sequencing
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise  = scl_i && !s_reg.scl_q;
        fall  = !scl_i && s_reg.scl_q;
        // R14 - clock-high edges are conditions
        // R12 - start recognised
        start = scl_i && s_reg.scl_q && s_reg.sda_q && !sda_i;
        // R13 - stop recognised
        stop  = scl_i && s_reg.scl_q && !s_reg.sda_q && sda_i;
        s_next  = s_reg;
        wr_buf  = 1'b0;
        s_next.scl_q = scl_i;
        s_next.sda_q = sda_i;
        if (s_reg.st == eeprom_port_pkg::ST_PROG) begin
            s_next.sda_low = 1'b0;
            if (s_reg.cnt != '0) begin
                s_next.cnt = s_reg.cnt - 16'h0001;
            end
            if (s_reg.nbuf != '0) begin
                s_next.nbuf = s_reg.nbuf - 1'b1;
            end else if (s_reg.cnt == '0) begin
                s_next.st = eeprom_port_pkg::ST_IDLE;
            end
        end else if (start) begin
            s_next.st      = eeprom_port_pkg::ST_RECV;
            s_next.bitn    = 4'h0;
            s_next.phase   = 2'h0;
            s_next.nbuf    = '0;
            s_next.sda_low = 1'b0;
        end else if (stop) begin
            s_next.sda_low = 1'b0;
            if (s_reg.nbuf != '0) begin
                s_next.st  = eeprom_port_pkg::ST_PROG;
                s_next.cnt = 16'(PROG_COUNT);
            end else begin
                s_next.st = eeprom_port_pkg::ST_IDLE;
            end
        end else begin
            case (s_reg.st)
                eeprom_port_pkg::ST_RECV: begin
                    if (rise) begin
                        s_next.shift = {s_reg.shift[6:0], sda_i};
                        s_next.bitn  = s_reg.bitn + 4'h1;
                    end
                    if (fall && s_reg.bitn == 4'h8) begin
                        s_next.bitn = 4'h0;
                        s_next.st   = eeprom_port_pkg::ST_ACK;
                        // R16 - acknowledge each byte, a control byte only when its upper four bits equal DEV_ADDR_CODE
                        // R18 - hold low through ack pulse
                        s_next.sda_low = 1'b1;
                        if (s_reg.phase == 2'h0) begin
                            s_next.rd_mode = s_reg.shift[0];
                            s_next.sda_low = (s_reg.shift[7:4] == `DEV_ADDR_CODE);
                            s_next.phase   = s_reg.shift[0] ? 2'h3 : 2'h1;
                        end else if (s_reg.phase == 2'h1) begin
                            s_next.addr  = AW'(s_reg.shift);
                            s_next.phase = 2'h2;
                        end else begin
                            // R15 - keep last sixteen bytes
                            wr_buf      = 1'b1;
                            s_next.head = s_reg.head + 1'b1;
                            s_next.addr = s_reg.addr + 1'b1;
                            if (s_reg.nbuf != (PW+1)'(PAGE)) begin
                                s_next.nbuf = s_reg.nbuf + 1'b1;
                            end
                        end
                    end
                end
                eeprom_port_pkg::ST_ACK: begin
                    if (fall) begin
                        s_next.sda_low = 1'b0;
                        if (!s_reg.sda_low) begin
                            s_next.st = eeprom_port_pkg::ST_IDLE;
                        end else if (s_reg.phase == 2'h3) begin
                            s_next.st      = eeprom_port_pkg::ST_SEND;
                            s_next.shift   = mem[s_reg.addr];
                            s_next.addr    = s_reg.addr + 1'b1;
                            s_next.sda_low = !mem[s_reg.addr][7];
                        end else begin
                            s_next.st = eeprom_port_pkg::ST_RECV;
                        end
                    end
                end
                eeprom_port_pkg::ST_SEND: begin
                    if (fall) begin
                        s_next.bitn = s_reg.bitn + 4'h1;
                        if (s_reg.bitn == 4'h7) begin
                            s_next.bitn    = 4'h0;
                            s_next.sda_low = 1'b0;
                            s_next.st      = eeprom_port_pkg::ST_MACK;
                        end else begin
                            s_next.shift   = {s_reg.shift[6:0], 1'b0};
                            s_next.sda_low = !s_reg.shift[6];
                        end
                    end
                end
                eeprom_port_pkg::ST_MACK: begin
                    if (rise && sda_i) begin
                        // R20 - release line after no-ack
                        s_next.st = eeprom_port_pkg::ST_IDLE;
                    end else if (rise) begin
                        // Next byte is fetched once this clock falls, so no byte is skipped
                        s_next.st      = eeprom_port_pkg::ST_ACK;
                        s_next.sda_low = 1'b1;
                    end
                end
                default: begin
                    s_next.sda_low = 1'b0;
                end
            endcase
        end
        if (!powered_i) begin
            s_next = '0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // R17 - no acknowledge while programming
    assign sda_low_o = s_reg.sda_low && (s_reg.st != eeprom_port_pkg::ST_PROG) && powered_i;
    assign busy_o    = (s_reg.st == eeprom_port_pkg::ST_PROG);
endmodule : serial_eeprom_core

// ### rtl/eeprom_two_wire_port.sv
// Wishbone-mapped port register that bit-bangs the embedded serial EEPROM
//
// How it works
// R1 - 128 bytes reached only over link
// R2 - bit 2 drives clock, bit 1 data
// R3 - bit 0 switches memory supply
// R4 - software makes every edge itself
// R5 - bits 7 to 3 read zero
// R6 - reset sets clock, data, power
// R7 - data one releases, zero pulls low
// R8 - power off tristates and resets memory
// R9 - power off reads all zero
// R10 - host starts only from idle bus
// R11 - host changes data only clock low
// R12 - start is data fall, clock high
// R13 - stop is data rise, clock high
// R14 - clock-high data change is condition
// R15 - write keeps last sixteen bytes
// R16 - memory acknowledges every received byte; a control byte whose code is not DEV_ADDR_CODE gets no ack
// R17 - no acknowledge during programming
// R18 - acknowledge low through clock high
// R19 - host no-acks final read byte
// R20 - memory releases data after no-ack
// R21 - data bit reads actual line
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
module eeprom_two_wire_port #(
    parameter int DEPTH      = `EEPROM_BYTES,
    parameter int PAGE       = `PAGE_BYTES,
    parameter int PROG_COUNT = `PROG_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    output logic             eeprom_power_o,
    output logic             eeprom_busy_o
);
    typedef struct packed {
        logic       clk_bit;
        logic       data_bit;
        logic       pwr_bit;
        logic       ack;
        logic       err;
        logic [31:0] rdata;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;
    logic        mem_sda_low;
    logic        mem_busy;
    logic        line_clk;
    logic        line_data;

    // R7 - open-drain data: low if either side pulls
    // R21 - readback sees shared line
    // R8 - unpowered memory lines tristate
    assign line_clk  = s_reg.clk_bit || !s_reg.pwr_bit;
    assign line_data = (s_reg.data_bit || !s_reg.pwr_bit) && !mem_sda_low;

    // R1 - storage reached only over the link
    serial_eeprom_core #(
        .DEPTH      (DEPTH),
        .PAGE       (PAGE),
        .PROG_COUNT (PROG_COUNT)
    ) u_mem (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .powered_i (s_reg.pwr_bit),
        .scl_i     (line_clk),
        .sda_i     (line_data),
        .sda_low_o (mem_sda_low),
        .busy_o    (mem_busy)
    );

    // Wishbone slave and port register
    always_comb begin
        logic req;
        req          = cyc_i && stb_i && !s_reg.ack && !s_reg.err;
        s_next       = s_reg;
        s_next.ack   = 1'b0;
        s_next.err   = 1'b0;
        s_next.rdata = 32'h0000_0000;
        if (req) begin
            if (adr_i == `PORT_CONTROL_OFFSET) begin
                s_next.ack = 1'b1;
                if (we_i && sel_i[0]) begin
                    // R2 - clock and data bits
                    // R4 - each write is one line edge
                    s_next.clk_bit  = dat_i[`BIT_CLOCK];
                    s_next.data_bit = dat_i[`BIT_DATA];
                    // R3 - supply switch
                    s_next.pwr_bit  = dat_i[`BIT_POWER];
                end
                // R9 - reads zero while unpowered
                // R5 - upper bits zero
                if (s_reg.pwr_bit) begin
                    s_next.rdata[`BIT_CLOCK] = s_reg.clk_bit;
                    s_next.rdata[`BIT_DATA]  = line_data;
                    s_next.rdata[`BIT_POWER] = 1'b1;
                end
            end else if (adr_i == `PORT_STATUS_OFFSET) begin
                s_next.ack      = 1'b1;
                s_next.rdata[0] = mem_busy;
            end else begin
                s_next.err = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // R6 - reset value all ones
            s_reg          <= '0;
            s_reg.clk_bit  <= 1'b1;
            s_reg.data_bit <= 1'b1;
            s_reg.pwr_bit  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dat_o          = s_reg.rdata;
    assign ack_o          = s_reg.ack;
    assign err_o          = s_reg.err;
    assign eeprom_power_o = s_reg.pwr_bit;
    assign eeprom_busy_o  = mem_busy;
endmodule : eeprom_two_wire_port

// ### tb/eeprom_two_wire_port_properties.sv
// Assertions on the port's bus face and memory status outputs
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
module eeprom_two_wire_port_properties #(
    parameter int DEPTH      = `EEPROM_BYTES,
    parameter int PAGE       = `PAGE_BYTES,
    parameter int PROG_COUNT = `PROG_CYCLES
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic        eeprom_power_o,
    input wire logic        eeprom_busy_o
);
    localparam int BUSY_MAX = PROG_COUNT + 4;
    logic tk;
    logic rd;
    // Taken request and port read answer
    assign tk = cyc_i && stb_i && !ack_o && !err_o;
    assign rd = ack_o && !we_i && adr_i == 8'h90;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_answer; tk |=> ack_o ^ err_o; endproperty
    a_answer: assert property (p_answer) else $error("request not answered once");
    property p_unmapped; tk && adr_i != 8'h90 && adr_i != 8'h94 |=> err_o && !ack_o; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_high; rd |-> dat_o[31:3] == 29'h0; endproperty
    a_high: assert property (p_high) else $error("upper port bits not zero");
    property p_off; rd && !eeprom_power_o |-> dat_o == 32'h0; endproperty
    a_off: assert property (p_off) else $error("port read not zero while unpowered");
    property p_power; tk && we_i && adr_i == 8'h90 && sel_i[0] |=> eeprom_power_o == $past(dat_i[0]); endproperty
    a_power: assert property (p_power) else $error("power bit not taken from write");
    property p_reset; $past(rst_i) |-> eeprom_power_o && !ack_o && !eeprom_busy_o; endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
    property p_idle; !eeprom_power_o [*3] |-> !eeprom_busy_o; endproperty
    a_idle: assert property (p_idle) else $error("memory busy while unpowered");
    property p_prog; $rose(eeprom_busy_o) |-> ##[1:BUSY_MAX] !eeprom_busy_o; endproperty
    a_prog: assert property (p_prog) else $error("programming cycle too long");
    // Main scenarios reached
    c_write: cover property (tk && we_i && adr_i == 8'h90);
    c_err: cover property (err_o);
    c_prog: cover property ($rose(eeprom_busy_o));
endmodule : eeprom_two_wire_port_properties

// ### tb/host_model.sv
// Software host model: bit-bangs the two-wire link through the port register
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rd_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] noise_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      wd_o
);
    logic [31:0] q;
    logic        e;
    // Bus idle at time zero
    initial {cyc_o, we_o, adr_o, sel_o, wd_o} = '0;
    // Classic cycle held until ack or err
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        {cyc_o, we_o, adr_o, wd_o, sel_o} <= {1'b1, w, a, d, s};
        @(posedge clk_i);
        while (ack_i !== 1'b1 && err_i !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rd_i;
        e = err_i;
        cyc_o <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Port write with power kept on; unused bits and lanes carry noise
    task automatic line(input logic c, input logic d);
        wb(1'b1, 8'h90, {noise_i[31:3], c, d, 1'b1}, {noise_i[3:1], 1'b1});
    endtask : line
    task automatic clk_bit(input logic d, output logic r);
        line(1'b0, d);
        line(1'b1, d);
        wb(1'b0, 8'h90, noise_i, noise_i[3:0]);
        r = q[1];
        line(1'b0, d);
    endtask : clk_bit
    task automatic cond(input logic d);
        line(1'b0, !d);
        line(1'b1, !d);
        line(1'b1, d);
        if (!d) line(1'b0, 1'b0);
    endtask : cond
    task automatic xfer(input logic [7:0] t, input logic a, output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(t[i], r[i]);
        end
        clk_bit(a, k);
    endtask : xfer
endmodule : host_model

// ### tb/eeprom_two_wire_port_bench.sv
// Self-checking bench of the EEPROM port with host model and byte model
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
`define CHECK(n, x, g) begin check_count++; if ((g) !== (x)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", n, x, g); end end
module eeprom_two_wire_port_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc, we, ack, err, pwr, busy, ak;
    logic [3:0]  sel;
    logic [7:0]  adr, rx, d, ctl;
    logic [31:0] wd, rd;
    logic [31:0] seed = 32'h733b;
    logic [31:0] noise = 32'h0;
    logic [7:0]  mem [128];
    logic [7:0]  page_q [$];
    int          base;
    int          n_errors = 0;
    int          check_count = 0;
    int          i;
    // Design with a programming time long enough to probe
    eeprom_two_wire_port #(.PROG_COUNT(400)) eeprom_two_wire_port_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
        .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .err_o(err),
        .eeprom_power_o(pwr), .eeprom_busy_o(busy));
    // Software host on the bus
    host_model host_model_inst (.clk_i(clk), .rd_i(rd), .ack_i(ack), .err_i(err), .noise_i(noise), .cyc_o(cyc),
        .we_o(we), .adr_o(adr), .sel_o(sel), .wd_o(wd));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Fresh noise for the bits and lanes the port ignores
    always @(posedge clk) noise <= rnd();
    // Verdict and end of run
    task automatic summarize();
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // Watchdog far beyond the expected run
    initial begin
        #1000000;
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        host_model_inst.wb(1'b0, 8'h90, 32'h0, 4'hf);
        `CHECK("port reset", 32'h7, host_model_inst.q)
        host_model_inst.wb(1'b1, 8'h90, 32'hff, 4'hf);
        host_model_inst.wb(1'b0, 8'h90, 32'h0, 4'hf);
        `CHECK("upper bits", 32'h7, host_model_inst.q)
        for (i = 0; i < 4; i++) begin
            rx = 8'(rnd());
            if (rx == 8'h90 || rx == 8'h94) rx = 8'h10;
            host_model_inst.wb(1'b1, rx, rnd(), 4'hf);
            `CHECK("unmapped", 1'b1, host_model_inst.e)
        end
        host_model_inst.wb(1'b1, 8'h90, 32'h6, 4'hf);
        `CHECK("power off", 1'b0, pwr)
        host_model_inst.wb(1'b1, 8'h90, 32'h7, 4'he);
        host_model_inst.wb(1'b0, 8'h90, 32'h0, 4'hf);
        `CHECK("off read", 32'h0, host_model_inst.q)
        host_model_inst.wb(1'b1, 8'h90, 32'h5, 4'hf);
        host_model_inst.wb(1'b0, 8'h90, 32'h0, 4'hf);
        `CHECK("data low", 32'h5, host_model_inst.q)
        host_model_inst.wb(1'b1, 8'h90, 32'h7, 4'hf);
        // Page write of eighteen bytes; only the last sixteen stay
        ctl = {`DEV_ADDR_CODE, 4'h0};
        host_model_inst.cond(1'b0);
        host_model_inst.xfer(ctl, 1'b1, rx, ak);
        host_model_inst.xfer(8'h25, 1'b1, rx, ak);
        `CHECK("ack address", 1'b0, ak)
        for (i = 0; i < 18; i++) begin
            d = 8'(rnd());
            page_q.push_back(d);
            if (page_q.size() > `PAGE_BYTES) rx = page_q.pop_front();
            host_model_inst.xfer(d, 1'b1, rx, ak);
            `CHECK("ack data", 1'b0, ak)
        end
        host_model_inst.cond(1'b1);
        // Kept bytes land just below the address after the last one
        base = 'h25 + 18 - page_q.size();
        for (i = 0; i < page_q.size(); i++) mem[base + i] = page_q[i];
        // Command during programming goes unanswered
        host_model_inst.cond(1'b0);
        host_model_inst.xfer(ctl, 1'b1, rx, ak);
        `CHECK("busy", 1'b1, busy)
        `CHECK("no ack", 1'b1, ak)
        host_model_inst.cond(1'b1);
        for (i = 0; i < 200; i++) begin
            host_model_inst.wb(1'b0, 8'h94, 32'h0, 4'hf);
            if (host_model_inst.q[0] === 1'b0) break;
        end
        `CHECK("status", 32'h0, host_model_inst.q)
        // Random read of the page, last byte not acknowledged
        host_model_inst.cond(1'b0);
        host_model_inst.xfer(ctl, 1'b1, rx, ak);
        host_model_inst.xfer(8'(base), 1'b1, rx, ak);
        host_model_inst.cond(1'b0);
        host_model_inst.xfer(ctl | 8'h1, 1'b1, rx, ak);
        `CHECK("ack read", 1'b0, ak)
        for (i = 0; i < 16; i++) begin
            host_model_inst.xfer(8'hff, i == 15, rx, ak);
            `CHECK("read byte", mem[base + i], rx)
        end
        `CHECK("released", 1'b1, ak)
        host_model_inst.cond(1'b1);
        summarize();
    end
endmodule : eeprom_two_wire_port_bench
// Checker on the top module's ports
bind eeprom_two_wire_port eeprom_two_wire_port_properties #(.DEPTH(DEPTH), .PAGE(PAGE), .PROG_COUNT(PROG_COUNT))
    eeprom_two_wire_port_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .eeprom_power_o(eeprom_power_o), .eeprom_busy_o(eeprom_busy_o));
